/* File: pel_map.svh */
/*
 * Constants of the peripheral enable and lock register bank: offsets,
 * field positions, reset values and the unlock key.
 * Assumes it is included by bare name from the design files.
 */
// Functional notes
// - Select bits 31:7 and bit 4 are reserved, read zero, ignore writes.
// - Bit 6 enables video port 2; zero powers it down; resets to 0.
// - Bit 5 enables video port 1; zero powers it down; resets to 0.
// - Bit 3 enables two-wire port 0; zero powers it down; resets to 0.
// - Bit 2, unsupported serial port 1 enable, resets to 1; software clears.
// - Bit 1 enables buffered serial port 0; resets to 1, enabled.
// - Bit 0 zero gives upper pins to video 1 while bit 5 enables it; one to audio port.
// - Video 1 lower pins follow video 1 and serial port 1 enables.
// - Upper group is video 1 lines 19:12 shared with audio lines 7:0.
// - Key 0x10C0010C written to the lock register unlocks select writes.
// - Lock register reads 1 while locked, 0 while unlocked.
// - Select writes act only while unlocked; locked writes change nothing.
// - Every write to the select register relocks it.
// - Lock comes out of reset locked, value 1.
`ifndef PEL_MAP_SVH
`define PEL_MAP_SVH

`define PEL_SELECT_ADDR 32'h01b3_f000
`define PEL_LOCK_ADDR 32'h01b3_f018
`define PEL_UNLOCK_KEY 32'h10c0_010c
`define PEL_SELECT_WMASK 7'h6f
`define PEL_SELECT_RESET 7'h06
`define PEL_LOCK_RESET 1'b1
`define PEL_BIT_VIDEO2 6
`define PEL_BIT_VIDEO1 5
`define PEL_BIT_TWOWIRE0 3
`define PEL_BIT_SERIAL1 2
`define PEL_BIT_SERIAL0 1
`define PEL_BIT_AUDIO 0
`define PEL_VIDEO1_UPPER_HI 19
`define PEL_VIDEO1_UPPER_LO 12
`define PEL_AUDIO_LINES 8
`define PEL_ENABLE_WAIT_NS 12800
`define PEL_CLK_NS 100
`define PEL_ENABLE_WAIT_CYCLES (`PEL_ENABLE_WAIT_NS / `PEL_CLK_NS)

`endif

/* File: pel_pin_mux.sv */
/*
 * Registered pin ownership for the shared video 1 and audio serial pins.
 * Assumes the select value comes from logic on the same clock.
 */
`include "pel_map.svh"

module pel_pin_mux (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire pel_pkg::pel_select_t select_i,
    output logic video1_upper_pins_on_o,
    output logic video1_lower_pins_on_o,
    output logic audio_serial_on_o,
    output logic [`PEL_AUDIO_LINES-1:0] audio_serial_data_pins_on_o
);

    // ****************************************
    // Pin ownership decode
    // ****************************************
    wire upper_to_video = select_i[`PEL_BIT_VIDEO1] &
        ~select_i[`PEL_BIT_AUDIO];
    wire lower_to_video = select_i[`PEL_BIT_VIDEO1] &
        ~select_i[`PEL_BIT_SERIAL1];
    wire audio_sel = select_i[`PEL_BIT_AUDIO];

    // ****************************************
    // Output flops
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            video1_upper_pins_on_o <= 1'b0;
            video1_lower_pins_on_o <= 1'b0;
            audio_serial_on_o <= 1'b0;
            audio_serial_data_pins_on_o <= '0;
        end else begin
            video1_upper_pins_on_o <= upper_to_video;
            video1_lower_pins_on_o <= lower_to_video;
            audio_serial_on_o <= audio_sel;
            audio_serial_data_pins_on_o <=
                {`PEL_AUDIO_LINES{audio_sel}};
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_upper_owner;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        1'b1 |=> video1_upper_pins_on_o ==
            ($past(select_i[5]) && !$past(select_i[0]));
    endproperty
    a_upper_owner: assert property (p_upper_owner)
        else $error("Upper pins owner wrong");

    property p_lower_owner;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        1'b1 |=> video1_lower_pins_on_o ==
            ($past(select_i[5]) && !$past(select_i[2]));
    endproperty
    a_lower_owner: assert property (p_lower_owner)
        else $error("Lower pins owner wrong");

    property p_audio_lines;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        audio_serial_on_o |-> audio_serial_data_pins_on_o == 8'hff &&
            !video1_upper_pins_on_o;
    endproperty
    a_audio_lines: assert property (p_audio_lines)
        else $error("Audio lines not all granted");

endmodule // pel_pin_mux

/* File: pel_pkg.sv */
/*
 * Types of the peripheral enable and lock register bank.
 * Assumes nothing of its surroundings.
 */
package pel_pkg;

    typedef enum logic [0:0] {
        PEL_UNLOCKED = 1'b0,
        PEL_LOCKED = 1'b1
    } pel_lock_e;

    typedef logic [6:0] pel_select_t;

endpackage

/* File: pel_regs.sv */
/*
 * Peripheral select register with key-protected lock, reached over the
 * CPU configuration bus: one-cycle read and write strobes, answer a cycle
 * later. Assumes bus signals come from logic on core_clk_i.
 */
`include "pel_map.svh"

module pel_regs (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,
    output logic video2_on_o,
    output logic video1_on_o,
    output logic twowire0_on_o,
    output logic buffered_serial1_on_o,
    output logic buffered_serial0_on_o,
    output logic video1_upper_pins_on_o,
    output logic video1_lower_pins_on_o,
    output logic audio_serial_on_o,
    output logic [`PEL_AUDIO_LINES-1:0] audio_serial_data_pins_on_o
);

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ****************************************
    // State
    // ****************************************
    pel_pkg::pel_select_t peripheral_select_reg;
    pel_pkg::pel_select_t peripheral_select_next;
    pel_pkg::pel_lock_e lock_state_flag_reg;
    pel_pkg::pel_lock_e lock_state_flag_next;

    // ****************************************
    // Decode
    // ****************************************
    wire hit_select = cfg_addr_i == `PEL_SELECT_ADDR;
    wire hit_lock = cfg_addr_i == `PEL_LOCK_ADDR;
    wire select_wr = cfg_wr_i & hit_select;
    wire lock_wr = cfg_wr_i & hit_lock;
    wire key_ok = cfg_wdata_i == `PEL_UNLOCK_KEY;
    wire unlocked = lock_state_flag_reg == pel_pkg::PEL_UNLOCKED;
    wire select_take = select_wr & unlocked;
    wire [6:0] wmask = `PEL_SELECT_WMASK;

    // Reserved bits never take write data
    assign peripheral_select_next = select_take ?
        pel_pkg::pel_select_t'((cfg_wdata_i[6:0] & wmask) |
        (peripheral_select_reg & ~wmask)) :
        peripheral_select_reg;

    // Any select write relocks; only the key unlocks
    assign lock_state_flag_next = select_wr ? pel_pkg::PEL_LOCKED :
        (lock_wr && key_ok) ? pel_pkg::PEL_UNLOCKED :
        lock_state_flag_reg;

    wire [31:0] select_view = {25'h000_0000, peripheral_select_reg};
    wire [31:0] lock_view = {31'h0000_0000, lock_state_flag_reg};
    wire [31:0] read_value = hit_select ? select_view :
        hit_lock ? lock_view : 32'h0000_0000;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            peripheral_select_reg <= `PEL_SELECT_RESET;
            lock_state_flag_reg <= pel_pkg::PEL_LOCKED;
        end else begin
            peripheral_select_reg <= peripheral_select_next;
            lock_state_flag_reg <= lock_state_flag_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= 32'h0000_0000;
            cfg_ack_o <= 1'b0;
        end else begin
            cfg_ack_o <= cfg_rd_i | cfg_wr_i;
            if (cfg_rd_i) begin
                cfg_rdata_o <= read_value;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            video2_on_o <= 1'b0;
            video1_on_o <= 1'b0;
            twowire0_on_o <= 1'b0;
            buffered_serial1_on_o <= 1'b1;
            buffered_serial0_on_o <= 1'b1;
        end else begin
            video2_on_o <= peripheral_select_next[`PEL_BIT_VIDEO2];
            video1_on_o <= peripheral_select_next[`PEL_BIT_VIDEO1];
            twowire0_on_o <= peripheral_select_next[`PEL_BIT_TWOWIRE0];
            buffered_serial1_on_o <=
                peripheral_select_next[`PEL_BIT_SERIAL1];
            buffered_serial0_on_o <=
                peripheral_select_next[`PEL_BIT_SERIAL0];
        end
    end

    // ****************************************
    // Shared pins
    // ****************************************
    pel_pin_mux u_pin_mux (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .select_i(peripheral_select_reg),
        .video1_upper_pins_on_o(video1_upper_pins_on_o),
        .video1_lower_pins_on_o(video1_lower_pins_on_o),
        .audio_serial_on_o(audio_serial_on_o),
        .audio_serial_data_pins_on_o(audio_serial_data_pins_on_o)
    );

    // ****************************************
    // Checks
    // ****************************************
    property p_reserved_zero;
        cfg_rd_i && hit_select |=>
            cfg_rdata_o[31:7] == 25'h000_0000 && !cfg_rdata_o[4];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("Reserved select bits read nonzero");

    property p_video2_write;
        select_take |=> video2_on_o == $past(cfg_wdata_i[6]);
    endproperty
    a_video2_write: assert property (p_video2_write)
        else $error("Video 2 enable did not follow write");

    property p_twowire_write;
        select_take |=> twowire0_on_o == $past(cfg_wdata_i[3]) &&
            peripheral_select_reg[3] == twowire0_on_o;
    endproperty
    a_twowire_write: assert property (p_twowire_write)
        else $error("Two-wire enable did not follow write");

    property p_locked_write;
        select_wr && !unlocked |=> $stable(peripheral_select_reg) &&
            $stable(video1_on_o);
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("Locked write changed select register");

    property p_relock;
        select_wr |=> lock_state_flag_reg == pel_pkg::PEL_LOCKED;
    endproperty
    a_relock: assert property (p_relock)
        else $error("Select write did not relock");

    property p_key_unlocks;
        lock_wr && key_ok && !cfg_rd_i |=> unlocked;
    endproperty
    a_key_unlocks: assert property (p_key_unlocks)
        else $error("Key did not unlock");

    property p_bad_key;
        lock_wr && !key_ok |=> $stable(lock_state_flag_reg);
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("Wrong key changed lock state");

    property p_lock_read;
        cfg_rd_i && hit_lock |=> cfg_ack_o &&
            cfg_rdata_o == {31'h0000_0000, $past(lock_state_flag_reg)};
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("Lock read value wrong");

    property p_video1_write;
        select_take |=> video1_on_o == $past(cfg_wdata_i[5]);
    endproperty
    a_video1_write: assert property (p_video1_write)
        else $error("Video 1 enable did not follow write");

    property p_serial1_write;
        select_take |=> buffered_serial1_on_o == $past(cfg_wdata_i[2]);
    endproperty
    a_serial1_write: assert property (p_serial1_write)
        else $error("Serial 1 enable did not follow write");

    property p_serial0_write;
        select_take |=> buffered_serial0_on_o == $past(cfg_wdata_i[1]);
    endproperty
    a_serial0_write: assert property (p_serial0_write)
        else $error("Serial 0 enable did not follow write");

    property p_reserved_kept;
        select_take |=> !peripheral_select_reg[4];
    endproperty
    a_reserved_kept: assert property (p_reserved_kept)
        else $error("Reserved select bit took write data");

    property p_audio_write;
        select_take |=> peripheral_select_reg[0] == $past(cfg_wdata_i[0]);
    endproperty
    a_audio_write: assert property (p_audio_write)
        else $error("Pin select bit did not follow write");

    property p_locked_outputs;
        select_wr && !unlocked |=> $stable(video2_on_o) &&
            $stable(twowire0_on_o) && $stable(buffered_serial0_on_o);
    endproperty
    a_locked_outputs: assert property (p_locked_outputs)
        else $error("Locked write changed an enable output");

    property p_select_read;
        cfg_rd_i && hit_select |=>
            cfg_rdata_o[6:0] == $past(peripheral_select_reg);
    endproperty
    a_select_read: assert property (p_select_read)
        else $error("Select read value wrong");

    property p_write_acked;
        cfg_wr_i |=> cfg_ack_o;
    endproperty
    a_write_acked: assert property (p_write_acked)
        else $error("Write not acknowledged");

endmodule // pel_regs

/* File: tb_top.sv */
/*
 * Self-checking bench for the peripheral select and lock registers.
 * Assumes pel_map.svh and pel_pkg are compiled before this file.
 */
`include "pel_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ********************
    // Signals
    // ********************
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [31:0] cfg_addr_i = 32'h0000_0000;
    logic cfg_wr_i = 1'b0;
    logic cfg_rd_i = 1'b0;
    logic [31:0] cfg_wdata_i = 32'h0000_0000;
    logic [31:0] cfg_rdata_o;
    logic cfg_ack_o;
    logic video2_on_o, video1_on_o, twowire0_on_o;
    logic buffered_serial1_on_o, buffered_serial0_on_o;
    logic video1_upper_pins_on_o, video1_lower_pins_on_o, audio_serial_on_o;
    logic [7:0] audio_serial_data_pins_on_o;
    logic [31:0] outs;
    logic [31:0] rd_val;
    logic [31:0] wr_tab [3] = '{32'hffff_ffff, 32'h0000_0020, 32'h0000_0021};
    logic [31:0] out_tab [3] = '{32'h0000_f9ff, 32'h0000_4600, 32'h0000_43ff};
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    // Packed view of all enable and pin outputs
    assign outs = {16'h0000, video2_on_o, video1_on_o, twowire0_on_o,
        buffered_serial1_on_o, buffered_serial0_on_o, video1_upper_pins_on_o,
        video1_lower_pins_on_o, audio_serial_on_o, audio_serial_data_pins_on_o};

    always #50 core_clk_i = ~core_clk_i;

    pel_regs pel_regs_inst (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .cfg_addr_i(cfg_addr_i),
        .cfg_wr_i(cfg_wr_i),
        .cfg_rd_i(cfg_rd_i),
        .cfg_wdata_i(cfg_wdata_i),
        .cfg_rdata_o(cfg_rdata_o),
        .cfg_ack_o(cfg_ack_o),
        .video2_on_o(video2_on_o),
        .video1_on_o(video1_on_o),
        .twowire0_on_o(twowire0_on_o),
        .buffered_serial1_on_o(buffered_serial1_on_o),
        .buffered_serial0_on_o(buffered_serial0_on_o),
        .video1_upper_pins_on_o(video1_upper_pins_on_o),
        .video1_lower_pins_on_o(video1_lower_pins_on_o),
        .audio_serial_on_o(audio_serial_on_o),
        .audio_serial_data_pins_on_o(audio_serial_data_pins_on_o)
    );

    // ********************
    // Tasks
    // ********************
    task automatic give_verdict();
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_bus(input logic [31:0] addr, input logic [31:0] data);
        @(negedge core_clk_i);
        cfg_addr_i = addr;
        cfg_wdata_i = data;
        cfg_wr_i = 1'b1;
        @(negedge core_clk_i);
        cfg_wr_i = 1'b0;
        chk({31'h0, cfg_ack_o}, 32'h0000_0001);
    endtask

    task automatic rd_bus(input logic [31:0] addr, output logic [31:0] data);
        @(negedge core_clk_i);
        cfg_addr_i = addr;
        cfg_rd_i = 1'b1;
        @(negedge core_clk_i);
        cfg_rd_i = 1'b0;
        chk({31'h0, cfg_ack_o}, 32'h0000_0001);
        data = cfg_rdata_o;
    endtask

    // ********************
    // Timeout
    // ********************
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end

    // ********************
    // Tests
    // ********************
    initial begin
        repeat (8) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        @(negedge core_clk_i);
        chk(outs, 32'h0000_1800);
        rd_bus(`PEL_SELECT_ADDR, rd_val);
        chk(rd_val, 32'h0000_0006);
        rd_bus(`PEL_LOCK_ADDR, rd_val);
        chk(rd_val, 32'h0000_0001);
        wr_bus(`PEL_SELECT_ADDR, 32'h0000_0068);
        rd_bus(`PEL_SELECT_ADDR, rd_val);
        chk(rd_val, 32'h0000_0006);
        wr_bus(`PEL_LOCK_ADDR, 32'h10c0_010d);
        wr_bus(`PEL_SELECT_ADDR, 32'h0000_0068);
        rd_bus(`PEL_SELECT_ADDR, rd_val);
        chk(rd_val, 32'h0000_0006);
        for (int i = 0; i < 3; i++) begin
            wr_bus(`PEL_LOCK_ADDR, 32'h10c0_010c);
            rd_bus(`PEL_LOCK_ADDR, rd_val);
            chk(rd_val, 32'h0000_0000);
            wr_bus(`PEL_SELECT_ADDR, wr_tab[i]);
            repeat (`PEL_ENABLE_WAIT_CYCLES) @(negedge core_clk_i);
            chk(outs, out_tab[i]);
            rd_bus(`PEL_SELECT_ADDR, rd_val);
            chk(rd_val, wr_tab[i] & 32'h0000_006f);
            rd_bus(`PEL_LOCK_ADDR, rd_val);
            chk(rd_val, 32'h0000_0001);
        end
        wr_bus(`PEL_SELECT_ADDR, 32'h0000_0000);
        rd_bus(`PEL_SELECT_ADDR, rd_val);
        chk(rd_val, 32'h0000_0021);
        wr_bus(32'h01b3_f008, 32'hffff_ffff);
        rd_bus(32'h01b3_f008, rd_val);
        chk(rd_val, 32'h0000_0000);
        @(negedge core_clk_i);
        rst_n_i = 1'b0;
        @(negedge core_clk_i);
        rst_n_i = 1'b1;
        @(negedge core_clk_i);
        chk(outs, 32'h0000_1800);
        rd_bus(`PEL_LOCK_ADDR, rd_val);
        chk(rd_val, 32'h0000_0001);
        give_verdict();
    end

endmodule // tb_top
